// ### verilog/sdr_rx_chain.sv
// Receive DSP chain: serial audio in, sideband demodulation, audio stream out
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Incoming I and Q samples, 24 bits each, are gathered in blocks of 32 pairs before a block is processed.
// - The signal is rotated up by a quarter of the sample rate to a 12 kHz IF and low-passed while decimating by four.
// - A Hilbert transformer shifts one quadrature path by 90 degrees against the other, which is delayed to match.
// - The two paths are added for one sideband and subtracted for the other, and either can be chosen.
// - After reset, until told otherwise, the upper sideband is demodulated.
// - The demodulated audio passes a band-pass filter from 150 Hz to 3.2 kHz.
// - The filtered audio is interpolated back up to 48 ksps.
// - The 48 ksps audio samples are handed to the host over the audio stream port.
// - Work runs at full internal width and every output sample is rounded to 24 bits.
// - Voice-operated keying is an option that is off by default, and while off the host keys by command.
// - A transmit-enable output drives the transmit stage on while transmitting and off on receive.
// - A status indicator shows transmit, receive and firmware-update mode distinctly.
// - Each frame holds two 32-bit slots, left and right, with 24 data bits in each.
// - The converter master clock is stepped for 512 times the audio sample rate, but at the 40 MHz system clock it folds to 15.424 MHz.
module sdr_rx_chain
  import sdr_rx_pkg::*;
#(
  parameter int unsigned LED_RX_CYC = LED_RX_MS * CYC_PER_MS,
  parameter int unsigned LED_FW_CYC = LED_FW_MS * CYC_PER_MS
) (
  input wire logic mclk,
  input wire logic rst_n,
  output logic adc_mclk,
  input wire logic adc_bclk,
  input wire logic adc_lrck,
  input wire logic adc_sdata,
  input wire logic lsb_select,
  input wire logic vox_enable,
  input wire logic vox_audio_present,
  input wire logic tx_cmd,
  input wire logic fw_update_mode,
  output logic tx_enable,
  output logic status_led,
  output logic usb_valid,
  input wire logic usb_ready,
  output logic [SAMPLE_W-1:0] usb_data,
  output logic block_overrun
);
  // Converter master clock
  logic [31:0] mclk_acc_q;
  // Serial audio receive
  logic bclk_s;
  logic lrck_s;
  logic sdata_s;
  logic bclk_prev_q;
  logic lrck_prev_q;
  logic [5:0] bit_cnt_q;
  logic [SAMPLE_W-1:0] shift_q;
  logic [SAMPLE_W-1:0] i_hold_q;
  wire bclk_rise;
  wire lrck_edge;
  wire word_done;
  wire [SAMPLE_W-1:0] word_val;
  // Block buffer, two banks
  logic signed [SAMPLE_W-1:0] buf_i [0:2*BLOCK_LEN-1];
  logic signed [SAMPLE_W-1:0] buf_q [0:2*BLOCK_LEN-1];
  logic [BLOCK_AW:0] wr_idx_q;
  logic blk_done_q;
  wire pair_done;
  // Processing
  proc_e state_q;
  logic rd_bank_q;
  logic [BLOCK_AW-1:0] rd_idx_q;
  acc_t mix_i_q;
  acc_t mix_q_q;
  acc_t hi_q [0:HIL_TAPS-1];
  acc_t hq_q [0:HIL_TAPS-1];
  acc_t sb_q;
  acc_t hp_x1_q;
  acc_t hp_y_q;
  acc_t lp_y_q;
  acc_t prev_q;
  logic [2:0] sub_q;
  // Keying and status
  logic tx_enable_q;
  logic led_q;
  logic [31:0] led_cnt_q;

  // Master clock: MSB of an accumulator stepped for 512 x fs; above half the system rate it folds, so a
  // clean 512 x fs clock needs a faster source than this one
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mclk_acc_q <= '0;
    end else begin
      mclk_acc_q <= mclk_acc_q + MCLK_STEP;
    end
  end
  assign adc_mclk = mclk_acc_q[31];

  // Link pins come from the converter's bit clock domain
  sync2 u_sync_bclk (.clk(mclk), .rst_n(rst_n), .d(adc_bclk), .q(bclk_s));
  sync2 u_sync_lrck (.clk(mclk), .rst_n(rst_n), .d(adc_lrck), .q(lrck_s));
  sync2 u_sync_data (.clk(mclk), .rst_n(rst_n), .d(adc_sdata), .q(sdata_s));

  // Slot decode: the edge that shows a new word select is the one-bit delay, then 24 data bits MSB first
  assign bclk_rise = bclk_s && !bclk_prev_q;
  assign lrck_edge = lrck_s != lrck_prev_q;
  assign word_done = bclk_rise && !lrck_edge && (bit_cnt_q == WORD_LAST);
  assign word_val = {shift_q[SAMPLE_W-2:0], sdata_s};
  assign pair_done = word_done && lrck_s;

  // Bit counter and shifter; the 7 trailing bits of a slot are ignored
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bclk_prev_q <= 1'b0;
      lrck_prev_q <= 1'b0;
      bit_cnt_q <= SLOT_LAST;
      shift_q <= '0;
      i_hold_q <= '0;
    end else begin
      bclk_prev_q <= bclk_s;
      if (bclk_rise) begin
        lrck_prev_q <= lrck_s;
        if (lrck_edge) begin
          bit_cnt_q <= '0;
        end else if (bit_cnt_q != SLOT_LAST) begin
          bit_cnt_q <= bit_cnt_q + 1'b1;
        end
        if (!lrck_edge && bit_cnt_q < WORD_LAST + 1'b1) begin
          shift_q <= word_val;
        end
      end
      if (word_done && !lrck_s) begin
        i_hold_q <= word_val;
      end
    end
  end

  // Left slot is I, right slot is Q; a pair lands when the right word ends
  always_ff @(posedge mclk) begin
    if (pair_done) begin
      buf_i[wr_idx_q] <= i_hold_q;
      buf_q[wr_idx_q] <= word_val;
    end
  end

  // Write index walks one bank and rolls into the other
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_idx_q <= '0;
      blk_done_q <= 1'b0;
    end else begin
      blk_done_q <= pair_done && (wr_idx_q[BLOCK_AW-1:0] == BLOCK_LAST);
      if (pair_done) begin
        wr_idx_q <= wr_idx_q + 1'b1;
      end
    end
  end

  // Sample read and quarter-rate rotation by j^n
  wire [1:0] phase = rd_idx_q[1:0];
  wire [BLOCK_AW:0] rd_addr = {rd_bank_q, rd_idx_q};
  wire acc_t xi = acc_t'(buf_i[rd_addr]) <<< FRAC;
  wire acc_t xq = acc_t'(buf_q[rd_addr]) <<< FRAC;
  wire acc_t rot_i = (phase == 2'h0) ? xi : (phase == 2'h1) ? -xq : (phase == 2'h2) ? -xi : xq;
  wire acc_t rot_q = (phase == 2'h0) ? xq : (phase == 2'h1) ? xi : (phase == 2'h2) ? -xq : -xi;
  wire acc_t sum_i = (phase == 2'h0) ? rot_i : mix_i_q + rot_i;
  wire acc_t sum_q = (phase == 2'h0) ? rot_q : mix_q_q + rot_q;
  // Four-sample boxcar is the low-pass ahead of the decimation
  wire acc_t dec_i = sum_i >>> DECIM_SHIFT;
  wire acc_t dec_q = sum_q >>> DECIM_SHIFT;

  // Hilbert on I, Q delayed by the filter's centre tap
  // Older tap minus newer tap makes a cosine come out as a sine, so a positive tone adds in the upper sideband
  wire logic signed [32:0] d06 = 33'(hi_q[6]) - 33'(hi_q[0]);
  wire logic signed [32:0] d24 = 33'(hi_q[4]) - 33'(hi_q[2]);
  wire logic signed [49:0] hil_w = 50'(d06) * 50'(HIL_C3) + 50'(d24) * 50'(HIL_C1);
  wire acc_t hil = 32'(hil_w >>> COEF_SHIFT);
  wire acc_t dly = hq_q[3];
  // Low select level is the upper sideband, which is the reset default
  wire acc_t sb_new = lsb_select ? dly - hil : dly + hil;

  // High-pass pole then one-pole low-pass
  wire logic signed [47:0] hp_prod = 48'(hp_y_q) * 48'(HP_POLE);
  wire acc_t hp_new = sb_q - hp_x1_q + 32'(hp_prod >>> COEF_SHIFT);
  wire logic signed [48:0] lp_prod = 49'(33'(hp_new) - 33'(lp_y_q)) * 49'(LP_GAIN);
  wire acc_t lp_new = lp_y_q + 32'(lp_prod >>> COEF_SHIFT);

  // Linear interpolation over sub steps 1..4; step 4 lands on the new point
  wire logic signed [36:0] step_w = 37'(33'(lp_y_q) - 33'(prev_q)) * 37'(signed'({1'b0, sub_q}));
  wire acc_t interp = prev_q + 32'(step_w >>> DECIM_SHIFT);
  // Round half up then saturate to 24 bits
  wire logic signed [32:0] rnd_w = 33'(interp) + 33'(ROUND_HALF);
  wire logic signed [26:0] rnd_s = 27'(rnd_w >>> FRAC);
  wire logic [SAMPLE_W-1:0] out_word = (rnd_s > OUT_MAX) ? SAMPLE_W'(OUT_MAX) :
                                       (rnd_s < OUT_MIN) ? SAMPLE_W'(OUT_MIN) : SAMPLE_W'(rnd_s);
  wire push = state_q == P_PUSH;
  wire fifo_in_ready;

  // Block sequencer; a full block takes about 80 cycles unless the output stalls
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= P_IDLE;
      rd_bank_q <= 1'b0;
      rd_idx_q <= '0;
      sub_q <= 3'h1;
      block_overrun <= 1'b0;
    end else begin
      block_overrun <= blk_done_q && (state_q != P_IDLE);
      unique case (state_q)
        P_IDLE: begin
          if (blk_done_q) begin
            rd_bank_q <= ~wr_idx_q[BLOCK_AW];
            rd_idx_q <= '0;
            state_q <= P_MIX;
          end
        end
        P_MIX: begin
          rd_idx_q <= rd_idx_q + 1'b1;
          if (phase == PHASE_LAST) begin
            state_q <= P_HILB;
          end
        end
        P_HILB: state_q <= P_FILT;
        P_FILT: begin
          sub_q <= 3'h1;
          state_q <= P_PUSH;
        end
        P_PUSH: begin
          if (fifo_in_ready) begin
            sub_q <= sub_q + 1'b1;
            if (sub_q == INTERP_LAST) begin
              state_q <= (rd_idx_q == '0) ? P_IDLE : P_MIX;
            end
          end
        end
      endcase
    end
  end

  // Data path registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mix_i_q <= '0;
      mix_q_q <= '0;
      sb_q <= '0;
      hp_x1_q <= '0;
      hp_y_q <= '0;
      lp_y_q <= '0;
      prev_q <= '0;
      for (int k = 0; k < HIL_TAPS; k++) begin
        hi_q[k] <= '0;
        hq_q[k] <= '0;
      end
    end else begin
      if (state_q == P_MIX) begin
        mix_i_q <= sum_i;
        mix_q_q <= sum_q;
        if (phase == PHASE_LAST) begin
          hi_q[0] <= dec_i;
          hq_q[0] <= dec_q;
          for (int k = 1; k < HIL_TAPS; k++) begin
            hi_q[k] <= hi_q[k-1];
            hq_q[k] <= hq_q[k-1];
          end
        end
      end
      if (state_q == P_HILB) begin
        sb_q <= sb_new;
      end
      if (state_q == P_FILT) begin
        hp_x1_q <= sb_q;
        hp_y_q <= hp_new;
        lp_y_q <= lp_new;
      end
      if (push && fifo_in_ready && sub_q == INTERP_LAST) begin
        prev_q <= lp_y_q;
      end
    end
  end

  // Output buffer absorbs host jitter; a full buffer stalls the sequencer
  sync_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_out_fifo (
    .clk(mclk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(out_word),
    .out_valid(usb_valid),
    .out_ready(usb_ready),
    .out_data(usb_data)
  );

  // Keying: with voice keying off only the host command keys; never key during firmware update
  wire tx_req = (vox_enable ? vox_audio_present : tx_cmd) && !fw_update_mode;
  wire [31:0] led_limit = fw_update_mode ? LED_FW_CYC - 1 : LED_RX_CYC - 1;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tx_enable_q <= 1'b0;
    end else begin
      tx_enable_q <= tx_req;
    end
  end
  assign tx_enable = tx_enable_q;

  // Indicator: steady on in transmit, slow blink on receive, fast blink in update mode
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      led_cnt_q <= '0;
      led_q <= 1'b0;
    end else if (tx_enable_q) begin
      led_cnt_q <= '0;
      led_q <= 1'b1;
    end else if (led_cnt_q >= led_limit) begin
      led_cnt_q <= '0;
      led_q <= ~led_q;
    end else begin
      led_cnt_q <= led_cnt_q + 1'b1;
    end
  end
  assign status_led = led_q;
endmodule
`default_nettype wire

// ### verilog/sdr_rx_pkg.sv
// Shared constants and types for the receive DSP chain
package sdr_rx_pkg;
  // Clock and audio rates
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned FS_HZ = 48_000;
  localparam int unsigned MCLK_RATIO = 512;
  // Phase step of the converter master clock generator, 32-bit accumulator
  localparam longint unsigned MCLK_STEP_L = (longint'(MCLK_RATIO) * FS_HZ * (64'h1 << 32)) / CLK_HZ;
  localparam logic [31:0] MCLK_STEP = 32'(MCLK_STEP_L);

  // Serial audio frame layout
  localparam int SAMPLE_W = 24;
  localparam int SLOT_BITS = 32;
  localparam logic [5:0] SLOT_LAST = 6'(SLOT_BITS - 1);
  localparam logic [5:0] WORD_LAST = 6'(SAMPLE_W - 1);

  // Block and rate change
  localparam int BLOCK_LEN = 32;
  localparam int BLOCK_AW = 5;
  localparam logic [BLOCK_AW-1:0] BLOCK_LAST = BLOCK_AW'(BLOCK_LEN - 1);
  localparam int DECIM = 4;
  localparam logic [1:0] PHASE_LAST = 2'(DECIM - 1);
  localparam logic [2:0] INTERP_LAST = 3'(DECIM);
  localparam int DECIM_SHIFT = 2;

  // Internal precision: samples carry extra fraction bits
  typedef logic signed [31:0] acc_t;
  localparam int FRAC = 6;
  localparam acc_t ROUND_HALF = 32'sh0000_0020;
  localparam logic signed [26:0] OUT_MAX = 27'sh07F_FFFF;
  localparam logic signed [26:0] OUT_MIN = -27'sh080_0000;

  // Intermediate frequency is a quarter of the sample rate
  localparam int unsigned IF_HZ = FS_HZ / DECIM;

  // Hilbert transformer, 7 taps, Q15, odd taps are zero
  localparam int HIL_TAPS = 7;
  localparam int COEF_SHIFT = 15;
  localparam logic signed [15:0] HIL_C1 = 16'sh517D;
  localparam logic signed [15:0] HIL_C3 = 16'sh1B2A;

  // Audio band edges and the Q15 pole values set for them at the decimated rate
  localparam int unsigned BPF_LO_HZ = 150;
  localparam int unsigned BPF_HI_HZ = 3200;
  localparam logic signed [15:0] HP_POLE = 16'sh7655;
  localparam logic signed [15:0] LP_GAIN = 16'sh680A;

  // Output buffer
  localparam int FIFO_DEPTH = 16;

  // Status indicator half periods
  localparam int unsigned LED_RX_MS = 500;
  localparam int unsigned LED_FW_MS = 100;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

  typedef enum logic [2:0] {P_IDLE, P_MIX, P_HILB, P_FILT, P_PUSH} proc_e;
endpackage

// ### verilog/sync2.sv
// Two flip-flop synchroniser for one pin
`timescale 1ns/10ps
`default_nettype none
module sync2 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic meta_q;

  // First stage is read only by the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ### verilog/sync_fifo.sv
// Single clock FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module sync_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  wire do_wr;
  wire do_rd;

  // Extra pointer bit tells full from empty
  assign in_ready = !((wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]));
  assign out_valid = (wr_ptr_q != rd_ptr_q);
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  assign out_data = mem[rd_ptr_q[AW-1:0]];

  // Storage needs no reset
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/sdr_rx_chain_properties.sv
// Port-level assertions for the receive chain
`timescale 1ns/10ps
`default_nettype none
module sdr_rx_chain_checker
  import sdr_rx_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic adc_mclk,
  input wire logic vox_enable,
  input wire logic vox_audio_present,
  input wire logic tx_cmd,
  input wire logic fw_update_mode,
  input wire logic tx_enable,
  input wire logic status_led,
  input wire logic usb_valid,
  input wire logic usb_ready,
  input wire logic [SAMPLE_W-1:0] usb_data,
  input wire logic block_overrun
);
  // Keying request as the host sees it; update mode always wins
  wire logic key_req;
  assign key_req = (vox_enable ? vox_audio_present : tx_cmd) & !fw_update_mode;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_stall;
    usb_valid && !usb_ready;
  endsequence
  sequence s_fw_flip;
    fw_update_mode && $changed(status_led) ##1 fw_update_mode;
  endsequence
  property p_key;
    $past(rst_n) |-> tx_enable == $past(key_req);
  endproperty
  a_key: assert property (p_key) else $error("tx_enable does not follow the keying request");
  property p_fw;
    fw_update_mode ##1 1'h1 |-> !tx_enable;
  endproperty
  a_fw: assert property (p_fw) else $error("transmit during update mode");
  property p_rst;
    $rose(rst_n) |-> !tx_enable && !usb_valid && !status_led;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_hold;
    s_stall |=> usb_valid && $stable(usb_data);
  endproperty
  a_hold: assert property (p_hold) else $error("audio word lost during stall");
  property p_led_tx;
    tx_enable [*3] |-> status_led;
  endproperty
  a_led_tx: assert property (p_led_tx) else $error("indicator not steady in transmit");
  property p_led_fw;
    s_fw_flip |-> $stable(status_led);
  endproperty
  a_led_fw: assert property (p_led_fw) else $error("indicator flips too fast");
  property p_pulse;
    block_overrun |=> !block_overrun;
  endproperty
  a_pulse: assert property (p_pulse) else $error("overrun flag longer than a cycle");
  // The accumulator MSB never rests more than two cycles
  property p_mclk;
    $stable(adc_mclk) |-> ##[1:3] $changed(adc_mclk);
  endproperty
  a_mclk: assert property (p_mclk) else $error("converter clock stalled");
endmodule
`default_nettype wire

// ### verification/adc_model.sv
// Converter model: serial audio master sending a complex test tone
`timescale 1ns/10ps
`default_nettype none
module adc_model (
  input wire logic mclk,
  output logic bclk,
  output logic lrck,
  output logic sdata
);
  logic [23:0] tone_i[32];
  logic [23:0] tone_q[32];
  int n = 0;
  // Tone of 32 points a cycle, Q lagging so it sits in the upper sideband
  initial begin
    bclk = 1'h0;
    lrck = 1'h1;
    sdata = 1'h0;
    for (int k = 0; k < 32; k++) begin
      tone_i[k] = 24'($rtoi(1.0e6 * $cos(6.2831853 * k / 32)));
      tone_q[k] = 24'($rtoi(1.0e6 * $sin(6.2831853 * k / 32)));
    end
  end
  // Delay bit, 24 bits MSB first, then unused bits that flip every bit
  task automatic slot(input logic ch, input logic [23:0] w);
    for (int b = 0; b < 32; b++) begin
      repeat (3) @(posedge mclk);
      #1;
      bclk = 1'h0;
      if (b == 0) lrck = ch;
      sdata = (b >= 1 && b <= 24) ? w[24-b] : !sdata;
      repeat (3) @(posedge mclk);
      #1;
      bclk = 1'h1;
    end
  endtask
  // Bit clock stands still between bursts
  task automatic send(input int frames);
    for (int f = 0; f < frames; f++) begin
      slot(1'h0, tone_i[n]);
      slot(1'h1, tone_q[n]);
      n = (n + 1) % 32;
    end
    repeat (3) @(posedge mclk);
    #1;
    bclk = 1'h0;
  endtask
endmodule
`default_nettype wire

// ### verification/test_sdr_rx_chain.sv
// Self-checking bench for the receive chain
`timescale 1ns/10ps
`default_nettype none
module test_sdr_rx_chain
  import sdr_rx_pkg::*;
;
  localparam int unsigned RX_CYC = 20;
  localparam int unsigned FW_CYC = 6;
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic adc_mclk, adc_bclk, adc_lrck, adc_sdata, tx_enable, status_led, usb_valid, block_overrun;
  logic lsb_select = 1'h0, vox_enable = 1'h0, vox_audio_present = 1'h0, tx_cmd = 1'h0;
  logic fw_update_mode = 1'h0, hold_ready = 1'h0;
  logic [SAMPLE_W-1:0] usb_data;
  logic [1:0] cyc_q = 2'h0;
  wire logic usb_ready;
  int error_cnt = 0, comparisons = 0, cycles = 0, overruns = 0;
  logic signed [SAMPLE_W-1:0] words[$];
  // Sink takes two words of every four, or none while held
  assign usb_ready = !hold_ready && !cyc_q[1];
  always #12.5 mclk = !mclk;
  sdr_rx_chain #(.LED_RX_CYC(RX_CYC), .LED_FW_CYC(FW_CYC)) u_sdr_rx_chain (.mclk, .rst_n, .adc_mclk,
    .adc_bclk, .adc_lrck, .adc_sdata, .lsb_select, .vox_enable, .vox_audio_present, .tx_cmd,
    .fw_update_mode, .tx_enable, .status_led, .usb_valid, .usb_ready, .usb_data, .block_overrun);
  adc_model u_adc_model (.mclk, .bclk(adc_bclk), .lrck(adc_lrck), .sdata(adc_sdata));
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Output capture, overrun count and a hang limit
  always @(posedge mclk) begin
    cyc_q <= #1 cyc_q + 2'h1; // Sink pattern moves just after the edge, like every other input
    cycles++;
    if (rst_n && usb_valid === 1'h1 && usb_ready) words.push_back(usb_data);
    if (block_overrun === 1'h1) overruns++;
    if (cycles == 90000) begin
      error_cnt++;
      $display("MISMATCH %0t run too long", $time);
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic t_reset();
    check(32'(tx_enable), 32'h0);
    check(32'(usb_valid), 32'h0);
    check(32'(status_led), 32'h0);
  endtask
  // Every combination of the keying inputs
  task automatic t_keying();
    logic exp;
    for (int i = 0; i < 16; i++) begin
      {vox_enable, vox_audio_present, tx_cmd, fw_update_mode} = 4'(i);
      exp = (vox_enable ? vox_audio_present : tx_cmd) && !fw_update_mode;
      tick(3);
      check(32'(tx_enable), 32'(exp));
      if (exp) check(32'(status_led), 32'h1);
    end
    {vox_enable, vox_audio_present, tx_cmd, fw_update_mode} = 4'h0;
  endtask
  task automatic wait_flip(output int n);
    logic last;
    last = status_led;
    for (n = 0; n < 100 && status_led === last; n++) tick(1);
  endtask
  // Blink half period in receive or update mode
  task automatic t_led(input logic fw, input int exp);
    int n;
    fw_update_mode = fw;
    tick(3 * exp);
    wait_flip(n);
    wait_flip(n);
    check(32'(n), 32'(exp));
  endtask
  task automatic run(input logic lsb, input int blocks, output longint e);
    lsb_select = lsb;
    u_adc_model.send(BLOCK_LEN * blocks);
    tick(400);
    e = 0;
    for (int k = words.size() - 32; k < words.size(); k++) e += words[k] < 0 ? -longint'(words[k]) : words[k];
  endtask
  // Sink held over two blocks: the second block overruns and is lost, so three blocks of words follow
  task automatic t_sideband();
    longint e_up, e_lo;
    hold_ready = 1'h1;
    u_adc_model.send(2 * BLOCK_LEN);
    tick(300);
    check(32'(usb_valid), 32'h1);
    check(32'(overruns), 32'h1);
    hold_ready = 1'h0;
    run(1'h0, 2, e_up);
    check(32'(words.size()), 32'(3 * BLOCK_LEN));
    run(1'h1, 2, e_lo);
    check(32'(e_up > 4 * e_lo), 32'h1);
    check(32'(overruns), 32'h1);
  endtask
  initial begin
    tick(8);
    rst_n = 1'h1;
    t_reset();
    t_keying();
    t_led(1'h0, RX_CYC);
    t_led(1'h1, FW_CYC);
    fw_update_mode = 1'h0;
    t_sideband();
    print_verdict();
  end
endmodule
bind sdr_rx_chain sdr_rx_chain_checker u_sdr_rx_chain_checker (.mclk, .rst_n, .adc_mclk, .vox_enable,
  .vox_audio_present, .tx_cmd, .fw_update_mode, .tx_enable, .status_led, .usb_valid, .usb_ready,
  .usb_data, .block_overrun);
`default_nettype wire
